/* logic/csio_core.sv */
// Clock-synchronous serial channel with APB register access
//
// Operation
// - Every frame carries exactly eight data bits, both directions.
// - Internal transfer clock is prescaled source divided by 2*(divider+1).
// - External clock source takes the transfer clock from the clock pin.
// - Transmit starts when enabled, buffer full, and CTS low if used.
// - Reception needs receive and transmit enable plus written transmit buffer.
// - Transmit interrupt when the buffer empties into the shift register or at shift completion, by select.
// - Receive interrupt when a frame moves into the receive buffer.
// - Unread buffer at next frame's seventh bit sets overrun, no interrupt.
// - Polarity 0 shifts on falling, samples on rising; 1 is opposite.
// - Frames go least or most significant bit first per bit order.
// - Continuous receive rearms reception on receive buffer read.
// - Inversion flips transmit bits when sent and received bits when read.
// - Data output idles high, or floats when open-drain, until first transfer.
// - Receive-only operation still shifts out the dummy transmit data.
// - Mode field 001b enables the channel; 000b disables and reinitialises.
// - Flow pin is general port, CTS input or RTS output per two bits.
// - Multi-pin clock bit drives transfer clock to one of two pins.
// - Unused alternate clock pin holds high for polarity 0, low for 1.
// - Without multi-pin clock, separation takes CTS from the shared pin while RTS keeps its pin.
// - RTS goes low when ready, high at first transfer clock falling edge.
// - CTS going high mid-frame stops the channel before the next frame.
`timescale 1ns/100ps
`default_nettype none

module csio_core
   import csio_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire csio_apb_req_t apb_i,
   output logic [31:0]        prdata_o,
   output logic               pready_o,
   output logic               pslverr_o,
   output logic               serial_out_pin_o,
   output logic               serial_out_pin_oe_o,
   input  wire logic          serial_in_pin_i,
   input  wire logic          xfer_clock_pin_i,
   output logic               xfer_clock_pin_o,
   output logic               xfer_clock_pin_oe_o,
   output logic               alternate_clock_pin_o,
   output logic               alternate_clock_pin_oe_o,
   input  wire logic          flow_pin_i,
   output logic               flow_pin_o,
   output logic               flow_pin_oe_o,
   input  wire logic          shared_alternate_pin_i,
   output logic               tx_irq_o,
   output logic               rx_irq_o
);

   csio_regs_t regs_reg;
   csio_regs_t regs_next;

   // Level accepted once second and third stages agree
   function automatic logic filt(input logic s2, input logic s3, input logic f);
      filt = (s2 == s3) ? s3 : f;
   endfunction

   function automatic logic filt_edge(input logic s2, input logic s3, input logic f);
      filt_edge = (s2 == s3) && (s3 != f);
   endfunction

   function automatic logic [4:0] presc_mask(input logic [1:0] sel);
      case (sel)
         2'h0:    presc_mask = CSIO_PRESC_F1;
         2'h1:    presc_mask = CSIO_PRESC_F2;
         2'h2:    presc_mask = CSIO_PRESC_F8;
         default: presc_mask = CSIO_PRESC_F32;
      endcase
   endfunction

   logic       acc_cyc;
   logic       setup_cyc;
   logic       chan_on;
   logic       cts_used;
   logic       cts_level;
   logic       start_ok;
   logic       edge_hit;
   logic       edge_lvl;
   logic       shift_edge;
   logic       sample_edge;
   logic       rx_bit;
   logic       alt_active;
   logic       clk_drive;
   logic       main_val;
   logic       alt_val;
   logic [7:0] inv_mask;

   assign acc_cyc   = apb_i.psel && apb_i.penable;
   assign setup_cyc = apb_i.psel && !apb_i.penable;

   always_comb begin
      regs_next = regs_reg;
      regs_next.tx_irq = 1'b0;
      regs_next.rx_irq = 1'b0;
      chan_on = (regs_reg.mode.channel_mode_field == CSIO_MODE_SYNC);
      inv_mask = regs_reg.ctrl.data_invert_select ? 8'hFF : 8'h00;
      edge_hit = 1'b0;
      edge_lvl = regs_reg.iclk;
      shift_edge = 1'b0;
      sample_edge = 1'b0;
      rx_bit = regs_reg.rx_f;

      // Pin synchronisers, three stages each
      regs_next.ck_s  = {regs_reg.ck_s[1:0], xfer_clock_pin_i};
      regs_next.ck_f  = filt(regs_reg.ck_s[1], regs_reg.ck_s[2], regs_reg.ck_f);
      regs_next.rx_s  = {regs_reg.rx_s[1:0], serial_in_pin_i};
      regs_next.rx_f  = filt(regs_reg.rx_s[1], regs_reg.rx_s[2], regs_reg.rx_f);
      regs_next.cts_s = {regs_reg.cts_s[1:0], flow_pin_i};
      regs_next.cts_f = filt(regs_reg.cts_s[1], regs_reg.cts_s[2], regs_reg.cts_f);
      regs_next.sh_s  = {regs_reg.sh_s[1:0], shared_alternate_pin_i};
      regs_next.sh_f  = filt(regs_reg.sh_s[1], regs_reg.sh_s[2], regs_reg.sh_f);

      // CTS source and use
      cts_used = !regs_reg.mode.flow_control_disable
                 && (!regs_reg.mode.flow_control_select
                     || (regs_reg.ctrl.flow_pin_separation
                         && !regs_reg.ctrl.multi_pin_clock_enable));
      cts_level = (regs_reg.ctrl.flow_pin_separation && regs_reg.mode.flow_control_select)
                  ? regs_reg.sh_f : regs_reg.cts_f;

      // APB read data captured in the setup cycle
      regs_next.prdata  = 32'h0000_0000;
      regs_next.pslverr = 1'b0;
      if (setup_cyc) begin
         case (apb_i.paddr)
            CSIO_OFS_MODE:   regs_next.prdata = {20'h00000, regs_reg.mode};
            CSIO_OFS_CTRL:   regs_next.prdata = {24'h000000, regs_reg.ctrl};
            CSIO_OFS_STATUS: regs_next.prdata = {28'h0000000, regs_reg.stat};
            CSIO_OFS_BAUD:   regs_next.prdata = {24'h000000, regs_reg.baud_divider};
            CSIO_OFS_TXBUF:  regs_next.prdata = {24'h000000, regs_reg.tx_buffer_register};
            CSIO_OFS_RXBUF:
               regs_next.prdata = {24'h000000, regs_reg.rx_buffer_register ^ inv_mask};
            default:         regs_next.pslverr = 1'b1;
         endcase
      end else if (acc_cyc) begin
         regs_next.pslverr = regs_reg.pslverr;
         regs_next.prdata  = regs_reg.prdata;
      end

      // APB write and read side effects
      if (acc_cyc && apb_i.pwrite) begin
         case (apb_i.paddr)
            CSIO_OFS_MODE: begin
               regs_next.mode = csio_mode_t'(apb_i.pwdata[11:0]);
               if (apb_i.pwdata[2:0] == CSIO_MODE_OFF) begin
                  regs_next.st = CSIO_ST_IDLE;
                  regs_next.stat = CSIO_REGS_RST.stat;
                  regs_next.ovr_frame = 1'b0;
                  regs_next.rx_bits = 4'h0;
                  regs_next.txd = 1'b1;
                  regs_next.rts = 1'b1;
               end
            end
            CSIO_OFS_CTRL:  regs_next.ctrl = csio_ctrl_t'(apb_i.pwdata[7:0]);
            CSIO_OFS_BAUD:  regs_next.baud_divider = apb_i.pwdata[7:0];
            CSIO_OFS_TXBUF: begin
               regs_next.tx_buffer_register = apb_i.pwdata[7:0];
               regs_next.stat.tx_buffer_empty_flag = 1'b0;
            end
            default: ;
         endcase
      end
      if (acc_cyc && !apb_i.pwrite && apb_i.paddr == CSIO_OFS_RXBUF) begin
         regs_next.stat.rx_complete_flag = 1'b0;
         if (regs_reg.ctrl.continuous_rx_enable)
            regs_next.stat.tx_buffer_empty_flag = 1'b0;
      end

      start_ok = chan_on && regs_reg.ctrl.tx_enable_bit
                 && !regs_reg.stat.tx_buffer_empty_flag
                 && (!cts_used || !cts_level);

      case (regs_reg.st)
         CSIO_ST_IDLE: begin
            regs_next.iclk = !regs_reg.mode.clock_polarity_select;
            regs_next.bcnt = 8'h00;
            regs_next.rx_bits = 4'h0;
            if (chan_on && !regs_reg.mode.flow_control_disable
                && regs_reg.mode.flow_control_select)
               regs_next.rts = !(regs_reg.ctrl.rx_enable_bit
                                 && !regs_reg.stat.rx_complete_flag);
            if (start_ok) begin
               regs_next.st = CSIO_ST_XFER;
               regs_next.tx_shift = regs_reg.tx_buffer_register ^ inv_mask;
               regs_next.stat.tx_buffer_empty_flag = 1'b1;
               regs_next.stat.shift_register_empty_flag = 1'b0;
               regs_next.ovr_frame = 1'b0;
               regs_next.presc = 5'h00;
               if (!regs_reg.ctrl.tx_irq_source_select)
                  regs_next.tx_irq = 1'b1;
            end
         end
         CSIO_ST_XFER: begin
            if (!chan_on) begin
               regs_next.st = CSIO_ST_IDLE;
            end else if (regs_reg.mode.clock_source_select) begin
               edge_hit = filt_edge(regs_reg.ck_s[1], regs_reg.ck_s[2], regs_reg.ck_f);
               edge_lvl = regs_reg.ck_s[2];
            end else begin
               regs_next.presc = regs_reg.presc + 5'h01;
               if ((regs_reg.presc & presc_mask(regs_reg.mode.presc_select)) == 5'h00) begin
                  if (regs_reg.bcnt == regs_reg.baud_divider) begin
                     regs_next.bcnt = 8'h00;
                     edge_hit = 1'b1;
                     edge_lvl = !regs_reg.iclk;
                     regs_next.iclk = edge_lvl;
                  end else begin
                     regs_next.bcnt = regs_reg.bcnt + 8'h01;
                  end
               end
            end
            shift_edge  = edge_hit && (edge_lvl == regs_reg.mode.clock_polarity_select);
            sample_edge = edge_hit && (edge_lvl != regs_reg.mode.clock_polarity_select);
            if (edge_hit && !edge_lvl && regs_reg.rx_bits == 4'h0)
               regs_next.rts = 1'b1;
            if (shift_edge) begin
               if (regs_reg.mode.bit_order_select) begin
                  regs_next.txd = regs_reg.tx_shift[7];
                  regs_next.tx_shift = {regs_reg.tx_shift[6:0], 1'b1};
               end else begin
                  regs_next.txd = regs_reg.tx_shift[0];
                  regs_next.tx_shift = {1'b1, regs_reg.tx_shift[7:1]};
               end
            end
            if (sample_edge) begin
               regs_next.rx_shift = regs_reg.mode.bit_order_select
                                    ? {regs_reg.rx_shift[6:0], rx_bit}
                                    : {rx_bit, regs_reg.rx_shift[7:1]};
               regs_next.rx_bits = regs_reg.rx_bits + 4'h1;
               if (regs_reg.rx_bits + 4'h1 == CSIO_BIT_OVR && regs_reg.ctrl.rx_enable_bit
                   && regs_reg.stat.rx_complete_flag) begin
                  regs_next.stat.overrun_flag = 1'b1;
                  regs_next.ovr_frame = 1'b1;
               end
               if (regs_reg.rx_bits + 4'h1 == CSIO_BITS_LAST) begin
                  regs_next.st = CSIO_ST_IDLE;
                  regs_next.rx_bits = 4'h0;
                  regs_next.stat.shift_register_empty_flag = 1'b1;
                  if (regs_reg.ctrl.tx_irq_source_select)
                     regs_next.tx_irq = 1'b1;
                  if (regs_reg.ctrl.rx_enable_bit && !regs_reg.ovr_frame
                      && !(regs_reg.rx_bits + 4'h1 == CSIO_BIT_OVR)) begin
                     regs_next.rx_buffer_register = regs_reg.mode.bit_order_select
                                    ? {regs_reg.rx_shift[6:0], rx_bit}
                                    : {rx_bit, regs_reg.rx_shift[7:1]};
                     regs_next.stat.rx_complete_flag = 1'b1;
                     regs_next.rx_irq = 1'b1;
                  end
               end
            end
         end
         default: regs_next.st = CSIO_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         regs_reg <= CSIO_REGS_RST;
      else
         regs_reg <= regs_next;
   end

   // Pin drive
   assign alt_active = regs_reg.ctrl.multi_pin_clock_enable && regs_reg.ctrl.alt_clock_pin_select;
   assign clk_drive  = chan_on && !regs_reg.mode.clock_source_select;
   assign main_val   = alt_active ? !regs_reg.mode.clock_polarity_select : regs_reg.iclk;
   assign alt_val    = alt_active ? regs_reg.iclk
                                  : !regs_reg.mode.clock_polarity_select;

   assign xfer_clock_pin_o         = main_val;
   assign xfer_clock_pin_oe_o      = clk_drive
                                     && !(regs_reg.mode.clock_open_drain_select && main_val);
   assign alternate_clock_pin_o    = alt_val;
   assign alternate_clock_pin_oe_o = clk_drive && regs_reg.ctrl.multi_pin_clock_enable
                                     && !(regs_reg.mode.clock_open_drain_select && alt_val);

   assign serial_out_pin_o    = regs_reg.txd;
   assign serial_out_pin_oe_o = chan_on
                                && !(regs_reg.mode.data_open_drain_select && regs_reg.txd);

   assign flow_pin_o    = regs_reg.rts;
   assign flow_pin_oe_o = chan_on && !regs_reg.mode.flow_control_disable
                          && regs_reg.mode.flow_control_select;

   assign prdata_o  = regs_reg.prdata;
   assign pready_o  = acc_cyc;
   assign pslverr_o = acc_cyc && regs_reg.pslverr;
   assign tx_irq_o  = regs_reg.tx_irq;
   assign rx_irq_o  = regs_reg.rx_irq;

endmodule

`default_nettype wire

/* logic/csio_pkg.sv */
// Constants, register layouts and state type of the synchronous serial channel
package csio_pkg;

   // Register byte offsets on the APB
   localparam logic [7:0] CSIO_OFS_MODE   = 8'h00;
   localparam logic [7:0] CSIO_OFS_CTRL   = 8'h04;
   localparam logic [7:0] CSIO_OFS_STATUS = 8'h08;
   localparam logic [7:0] CSIO_OFS_BAUD   = 8'h0C;
   localparam logic [7:0] CSIO_OFS_TXBUF  = 8'h10;
   localparam logic [7:0] CSIO_OFS_RXBUF  = 8'h14;

   // Channel mode field codes
   localparam logic [2:0] CSIO_MODE_OFF  = 3'h0;
   localparam logic [2:0] CSIO_MODE_SYNC = 3'h1;

   localparam int unsigned CSIO_FRAME_BITS = 8;
   localparam logic [3:0]  CSIO_BITS_LAST  = 4'h8;
   localparam logic [3:0]  CSIO_BIT_OVR    = 4'h7;

   // Prescaler masks for f1, f2, f8, f32
   localparam logic [4:0] CSIO_PRESC_F1  = 5'h00;
   localparam logic [4:0] CSIO_PRESC_F2  = 5'h01;
   localparam logic [4:0] CSIO_PRESC_F8  = 5'h07;
   localparam logic [4:0] CSIO_PRESC_F32 = 5'h1F;

   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } csio_apb_req_t;

   // Mode register, bits 11..0
   typedef struct packed {
      logic       clock_open_drain_select;
      logic       bit_order_select;
      logic       clock_polarity_select;
      logic       data_open_drain_select;
      logic       flow_control_disable;
      logic       flow_control_select;
      logic [1:0] presc_select;
      logic       clock_source_select;
      logic [2:0] channel_mode_field;
   } csio_mode_t;

   // Control register, bits 7..0
   typedef struct packed {
      logic flow_pin_separation;
      logic alt_clock_pin_select;
      logic multi_pin_clock_enable;
      logic data_invert_select;
      logic continuous_rx_enable;
      logic tx_irq_source_select;
      logic rx_enable_bit;
      logic tx_enable_bit;
   } csio_ctrl_t;

   // Status register, bits 3..0
   typedef struct packed {
      logic overrun_flag;
      logic shift_register_empty_flag;
      logic rx_complete_flag;
      logic tx_buffer_empty_flag;
   } csio_status_t;

   typedef enum logic [1:0] {
      CSIO_ST_IDLE = 2'b01,
      CSIO_ST_XFER = 2'b10
   } csio_state_t;

   typedef struct packed {
      csio_mode_t   mode;
      csio_ctrl_t   ctrl;
      csio_status_t stat;
      logic [7:0]   baud_divider;
      logic [7:0]   tx_buffer_register;
      logic [7:0]   rx_buffer_register;
      logic [7:0]   tx_shift;
      logic [7:0]   rx_shift;
      logic         ovr_frame;
      csio_state_t  st;
      logic [3:0]   rx_bits;
      logic [4:0]   presc;
      logic [7:0]   bcnt;
      logic         iclk;
      logic         txd;
      logic         rts;
      logic [2:0]   ck_s;
      logic         ck_f;
      logic [2:0]   rx_s;
      logic         rx_f;
      logic [2:0]   cts_s;
      logic         cts_f;
      logic [2:0]   sh_s;
      logic         sh_f;
      logic [31:0]  prdata;
      logic         pslverr;
      logic         tx_irq;
      logic         rx_irq;
   } csio_regs_t;

   localparam csio_regs_t CSIO_REGS_RST = '{
      mode: '0, ctrl: '0,
      stat: '{overrun_flag: 1'b0, shift_register_empty_flag: 1'b1,
              rx_complete_flag: 1'b0, tx_buffer_empty_flag: 1'b1},
      baud_divider: 8'h00, tx_buffer_register: 8'h00, rx_buffer_register: 8'h00,
      tx_shift: 8'h00, rx_shift: 8'h00, ovr_frame: 1'b0, st: CSIO_ST_IDLE,
      rx_bits: 4'h0, presc: 5'h00, bcnt: 8'h00, iclk: 1'b1, txd: 1'b1, rts: 1'b1,
      ck_s: 3'h7, ck_f: 1'b1, rx_s: 3'h7, rx_f: 1'b1, cts_s: 3'h7, cts_f: 1'b1,
      sh_s: 3'h7, sh_f: 1'b1, prdata: 32'h0000_0000, pslverr: 1'b0,
      tx_irq: 1'b0, rx_irq: 1'b0};

endpackage

/* tb/csio_core_asserts.sv */
// Concurrent checks on the serial channel ports
`timescale 1ns/100ps
`default_nettype none
module csio_core_asserts
   import csio_pkg::*;
(
   input wire logic          clk_i,
   input wire logic          rst_i,
   input wire csio_apb_req_t apb_i,
   input wire logic          pslverr_o,
   input wire logic          serial_out_pin_o,
   input wire logic          serial_out_pin_oe_o,
   input wire logic          xfer_clock_pin_o,
   input wire logic          xfer_clock_pin_oe_o,
   input wire logic          flow_pin_oe_o,
   input wire logic          tx_irq_o,
   input wire logic          rx_irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   csio_mode_t mode_reg;
   csio_ctrl_t ctrl_reg;
   logic [7:0] baud_reg;
   logic [9:0] cnt_reg;
   logic [3:0] smp_reg;
   logic       clk_q;
   wire logic  acc = apb_i.psel & apb_i.penable & apb_i.pwrite;
   wire logic  tog = xfer_clock_pin_o != clk_q;
   wire logic  idl = xfer_clock_pin_o != mode_reg.clock_polarity_select;
   wire logic  buf_acc = apb_i.psel && apb_i.paddr inside {CSIO_OFS_TXBUF, CSIO_OFS_RXBUF};
   // Shadow of mode, control and divider plus edge counters
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_reg <= '0;
         ctrl_reg <= '0;
         baud_reg <= 8'h00;
         cnt_reg  <= 10'h000;
         smp_reg  <= 4'h0;
         clk_q    <= 1'b1;
      end else begin
         clk_q   <= xfer_clock_pin_o;
         cnt_reg <= tog ? 10'h001 : cnt_reg + {9'h000, cnt_reg != 10'h3FF};
         if (buf_acc) smp_reg <= 4'h0;
         else if (tog && idl && xfer_clock_pin_oe_o) smp_reg <= smp_reg + 4'h1;
         if (acc && apb_i.paddr == CSIO_OFS_MODE) mode_reg <= apb_i.pwdata[11:0];
         if (acc && apb_i.paddr == CSIO_OFS_CTRL) ctrl_reg <= apb_i.pwdata[7:0];
         if (acc && apb_i.paddr == CSIO_OFS_BAUD) baud_reg <= apb_i.pwdata[7:0];
      end
   end
   chk_unmapped_err: assert property (
      apb_i.psel && apb_i.penable && apb_i.paddr > CSIO_OFS_RXBUF |-> pslverr_o)
      else $error("no error on unmapped access");
   chk_half_period: assert property (
      tog && idl && xfer_clock_pin_oe_o && $past(xfer_clock_pin_oe_o)
      && $past(xfer_clock_pin_oe_o, 2)
      && mode_reg.presc_select == 2'h0 |-> cnt_reg == {2'h0, baud_reg} + 10'h001)
      else $error("clock half period wrong");
   chk_shift_edge: assert property (
      serial_out_pin_oe_o && $past(serial_out_pin_oe_o) && xfer_clock_pin_oe_o
      && $changed(serial_out_pin_o) |-> !idl && (tog || cnt_reg == 10'h001))
      else $error("data moved off the shift edge");
   chk_idle_high: assert property (
      $rose(serial_out_pin_oe_o) && !mode_reg.data_open_drain_select |-> serial_out_pin_o)
      else $error("data output not high at enable");
   chk_rx_pulse: assert property (rx_irq_o |=> !rx_irq_o)
      else $error("receive pulse too long");
   chk_rx_eight: assert property (
      rx_irq_o |-> smp_reg + {3'h0, tog && idl} == 4'h8)
      else $error("receive event not after eighth bit");
   chk_tx_done: assert property (
      tx_irq_o && ctrl_reg.tx_irq_source_select |-> smp_reg + {3'h0, tog && idl} == 4'h8)
      else $error("transmit event not at completion");
   chk_flow_dir: assert property (
      flow_pin_oe_o |-> mode_reg.channel_mode_field == CSIO_MODE_SYNC
      && !mode_reg.flow_control_disable && mode_reg.flow_control_select)
      else $error("flow pin driven when not selected");
endmodule
`default_nettype wire

/* tb/csio_peer.sv */
// Behavioural synchronous serial peer clocked by the channel
`timescale 1ns/100ps
`default_nettype none
module csio_peer (
   input  wire logic       sclk_i,
   input  wire logic       pol_i,
   input  wire logic       msb_i,
   input  wire logic       sout_i,
   output var  logic       sin_o,
   output var  logic [7:0] rx_o
);
   logic [7:0] tx_reg;
   int         cnt = 8;
   initial sin_o = 1'b1;
   initial rx_o = 8'h00;
   task automatic start(input logic [7:0] b);
      tx_reg = b;
      cnt = 0;
   endtask
   // Drive on the shift edge, capture on the sample edge
   always @(sclk_i) begin
      if (sclk_i === pol_i && cnt < 8) begin
         sin_o <= msb_i ? tx_reg[7 - cnt] : tx_reg[cnt];
      end else if (sclk_i !== pol_i && cnt < 8) begin
         rx_o <= msb_i ? {rx_o[6:0], sout_i} : {sout_i, rx_o[7:1]};
         cnt <= cnt + 1;
         if (cnt == 7) sin_o <= ~sin_o;
      end
   end
endmodule
`default_nettype wire

/* tb/csio_core_test.sv */
// Self-checking bench for the synchronous serial channel
`timescale 1ns/100ps
`default_nettype none
module csio_core_test
   import csio_pkg::*;
;
   logic          clk_i = 1'b0;
   logic          rst_i = 1'b1;
   csio_apb_req_t req = '0;
   logic [31:0]   prdata_o;
   logic          pready_o, pslverr_o, sout, sout_oe, sin, ck_o, ck_oe, tx_irq_o, rx_irq_o;
   logic [7:0]    peer_rx, a, b;
   logic [33:0]   exp_q[$];
   logic [33:0]   e;
   int            miscompares = 0, n_checks = 0, cyc = 0, n_rx = 0, seed = 16573;
   csio_mode_t    m = '0;
   csio_ctrl_t    c = '0;
   always #50 clk_i = ~clk_i;
   csio_core i_csio_core (
      .clk_i, .rst_i, .apb_i(req), .prdata_o, .pready_o, .pslverr_o,
      .serial_out_pin_o(sout), .serial_out_pin_oe_o(sout_oe), .serial_in_pin_i(sin),
      .xfer_clock_pin_i(1'b1), .xfer_clock_pin_o(ck_o), .xfer_clock_pin_oe_o(ck_oe),
      .alternate_clock_pin_o(), .alternate_clock_pin_oe_o(), .flow_pin_i(1'b0),
      .flow_pin_o(), .flow_pin_oe_o(), .shared_alternate_pin_i(1'b0), .tx_irq_o, .rx_irq_o);
   csio_peer i_csio_peer (.sclk_i(ck_o), .pol_i(m.clock_polarity_select),
      .msb_i(m.bit_order_select), .sout_i(sout), .sin_o(sin), .rx_o(peer_rx));
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Read results are compared here against the oldest note
   always @(posedge clk_i) begin
      if (req.psel && req.penable && pready_o === 1'b1 && !req.pwrite) begin
         e = exp_q.pop_front();
         if (!e[33]) check({pslverr_o, prdata_o}, e[32:0]);
      end
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (rx_irq_o === 1'b1) n_rx++;
      if (cyc == 30000) begin
         miscompares++;
         results();
      end
   end
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                      input logic [33:0] ex);
      @(posedge clk_i);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
      if (!w) exp_q.push_back(ex);
      @(posedge clk_i);
      req.penable <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      req <= '0;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d, '0);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [32:0] ex);
      apb(1'b0, ad, 32'h0, {1'b0, ex});
   endtask
   task automatic setup(input logic pol, input logic msb, input logic inv, input logic cont);
      wr(CSIO_OFS_MODE, 32'h0);
      m = '{channel_mode_field: CSIO_MODE_SYNC, flow_control_select: 1'b1,
            clock_polarity_select: pol, bit_order_select: msb, default: 1'b0};
      c = '{tx_enable_bit: 1'b1, rx_enable_bit: 1'b1, tx_irq_source_select: 1'b1,
            data_invert_select: inv, continuous_rx_enable: cont, default: 1'b0};
      wr(CSIO_OFS_BAUD, 32'h00000007);
      wr(CSIO_OFS_MODE, {20'h0, m});
      wr(CSIO_OFS_CTRL, {24'h0, c});
      @(posedge clk_i);
      #1;
      check({32'h0, sout}, 33'h1);
   endtask
   // One frame, started by a buffer write or, in continuous mode, a read
   task automatic frame(input logic [7:0] tx, input logic [7:0] pb, input logic wr_tx,
                        input logic [33:0] rxe);
      i_csio_peer.start(pb);
      if (wr_tx)
         wr(CSIO_OFS_TXBUF, {24'h0, tx});
      else
         apb(1'b0, CSIO_OFS_RXBUF, 32'h0, rxe);
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk_i);
         #1;
         if (tx_irq_o === 1'b1) break;
      end
      @(posedge clk_i);
      check({25'h0, peer_rx}, {25'h0, c.data_invert_select ? ~tx : tx});
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(CSIO_OFS_STATUS, 33'h5);
      rd(CSIO_OFS_MODE, 33'h0);
      rd(8'h20, 33'h100000000);
      $display("test reset values done");
      for (int k = 0; k < 5; k++) begin
         setup(k[0], k[1], k[2], 1'b0);
         a = 8'($random(seed));
         b = 8'($random(seed));
         frame(a, b, 1'b1, '0);
         rd(CSIO_OFS_RXBUF, {25'h0, k[2] ? ~b : b});
         rd(CSIO_OFS_STATUS, 33'h5);
         $display("test frame config %0d done", k);
      end
      setup(1'b0, 1'b1, 1'b0, 1'b0);
      n_rx = 0;
      frame(a, b, 1'b1, '0);
      frame(b, a, 1'b1, '0);
      check(33'(n_rx), 33'h1);
      rd(CSIO_OFS_STATUS, 33'hF);
      wr(CSIO_OFS_MODE, 32'h0);
      rd(CSIO_OFS_STATUS, 33'h5);
      check({31'h0, sout_oe, ck_oe}, 33'h0);
      $display("test overrun and reinit done");
      setup(1'b1, 1'b0, 1'b0, 1'b1);
      frame(a, b, 1'b1, '0);
      frame(a, ~b, 1'b0, {26'h0, b});
      rd(CSIO_OFS_RXBUF, {25'h0, ~b});
      $display("test continuous receive done");
      results();
   end
endmodule
bind csio_core csio_core_asserts i_csio_core_asserts (
   .clk_i, .rst_i, .apb_i, .pslverr_o, .serial_out_pin_o, .serial_out_pin_oe_o,
   .xfer_clock_pin_o, .xfer_clock_pin_oe_o, .flow_pin_oe_o, .tx_irq_o, .rx_irq_o);
`default_nettype wire
